// [core/adcac_pkg.sv]
// ****************************************
// Shared constants
// ****************************************
package adcac_pkg;
  localparam int RES_W   = 12;
  localparam int ACC_W   = 14;
  localparam int CH_W    = 3;
  localparam int NCH     = 8;
  localparam int SR_N    = 4;
  localparam int NODE_W  = 2;
  localparam int LOOP_N  = 2;
  localparam int RESID_W = 8;
  localparam int DRL_W   = 2;
  localparam int CNT_W   = 12;
  // Module clock period, ps
  localparam int CLK_PS      = 25000;
  // Converter clock period, ps
  localparam int CONV_CLK_PS = 31250;
  // Startup calibration length in converter cycles
  localparam int STARTUP_CAL_START_CONV_CYC = 1920;
  // Least time, rounded up to module cycles
  localparam int STARTUP_CAL_START_CYC =
    (STARTUP_CAL_START_CONV_CYC * CONV_CLK_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [CNT_W-1:0] STARTUP_CAL_START_LAST = CNT_W'(STARTUP_CAL_START_CYC - 1);
  // Converter powered down out of reset
  localparam logic PD_RST = 1'b1;
  localparam logic [NCH-1:0] PEND_RST = 8'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_STARTUP_CAL_START = 3'b001,
    ST_IDLE  = 3'b010,
    ST_CONV  = 3'b011,
    ST_BGCAL = 3'b100
  } adcac_state_t;
endpackage : adcac_pkg

// [core/adcac_ev_route.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Service request routing
// ****************************************
module adcac_ev_route (
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          src_ev_i,
  input  wire logic                          res_ev_i,
  input  wire logic [adcac_pkg::NODE_W-1:0]  src_node_i,
  input  wire logic [adcac_pkg::NODE_W-1:0]  res_node_i,
  output logic      [adcac_pkg::SR_N-1:0]    sr_o
);
  genvar g;
  generate
    for (g = 0; g < adcac_pkg::SR_N; g++) begin : g_node
      // Both events may share one node in a cycle
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sr_o[g] <= 1'b0;
        end else begin
          sr_o[g] <= (src_ev_i && src_node_i == g) ||
                     (res_ev_i && res_node_i == g);
        end
      end
    end
  endgenerate

  chk_src_route: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    src_ev_i |=> sr_o[$past(src_node_i)])
    else $error("source event not on its node");
  chk_res_route: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    res_ev_i |=> sr_o[$past(res_node_i)])
    else $error("result event not on its node");
endmodule : adcac_ev_route
`default_nettype wire

// [core/adcac_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Converter activation and request control
// ****************************************
module adcac_ctrl (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           analog_powerdown_i,
  input  wire logic                           startup_cal_start_i,
  input  wire logic [adcac_pkg::NCH-1:0]      chan_sel_i,
  input  wire logic                           scan_en_i,
  input  wire logic [adcac_pkg::CH_W-1:0]     single_ch_i,
  input  wire logic                           autoscan_i,
  input  wire logic                           sw_trig_i,
  input  wire logic [3:0]                     hw_trig_i,
  input  wire logic [1:0]                     hw_trig_sel_i,
  input  wire logic                           hw_trig_en_i,
  input  wire logic [adcac_pkg::LOOP_N-1:0]   loop_en_i,
  input  wire logic [adcac_pkg::CH_W-1:0]     loop0_ch_i,
  input  wire logic [adcac_pkg::CH_W-1:0]     loop1_ch_i,
  input  wire logic                           wfr_en_i,
  input  wire logic                           result_read_i,
  input  wire logic                           dr_en_i,
  input  wire logic [adcac_pkg::DRL_W-1:0]    dr_len_i,
  input  wire logic [adcac_pkg::NODE_W-1:0]   src_node_i,
  input  wire logic [adcac_pkg::NODE_W-1:0]   res_node_i,
  input  wire logic                           core_done_i,
  input  wire logic [adcac_pkg::RES_W-1:0]    core_result_i,
  input  wire logic [adcac_pkg::RESID_W-1:0]  core_resid_i,
  output logic                                ana_pd_o,
  output logic                                cal_run_o,
  output logic                                cal_done_o,
  output logic                                conv_start_o,
  output logic [adcac_pkg::CH_W-1:0]          conv_ch_o,
  output logic [adcac_pkg::RESID_W-1:0]       resid_o,
  output logic                                resid_en_o,
  output logic                                bg_start_o,
  output logic                                bg_gain_o,
  output logic [adcac_pkg::ACC_W-1:0]         result_o,
  output logic [adcac_pkg::CH_W-1:0]          result_ch_o,
  output logic                                result_valid_o,
  output logic [adcac_pkg::NCH-1:0]           pend_o,
  output logic [adcac_pkg::SR_N-1:0]          sr_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [adcac_pkg::CH_W-1:0] hi_ch(
    input logic [adcac_pkg::NCH-1:0] m);
    logic [adcac_pkg::CH_W-1:0] r;
    r = '0;
    for (int i = 0; i < adcac_pkg::NCH; i++) begin
      if (m[i]) begin
        r = adcac_pkg::CH_W'(i);
      end
    end
    return r;
  endfunction : hi_ch

  function automatic logic loop_hit(
    input logic                       en,
    input logic [adcac_pkg::CH_W-1:0] lch,
    input logic [adcac_pkg::CH_W-1:0] ch);
    return en && (lch == ch);
  endfunction : loop_hit

  adcac_pkg::adcac_state_t state;
  logic [adcac_pkg::CNT_W-1:0]   cal_cnt;
  logic [adcac_pkg::NCH-1:0]     pend;
  logic [adcac_pkg::NCH-1:0]     load_pat;
  logic [adcac_pkg::DRL_W-1:0]   acc_cnt;
  logic [adcac_pkg::ACC_W-1:0]   acc;
  logic [adcac_pkg::ACC_W-1:0]   next_acc;
  logic [adcac_pkg::RESID_W-1:0] resid [adcac_pkg::LOOP_N];
  logic [adcac_pkg::CH_W-1:0]    loop_ch [adcac_pkg::LOOP_N];
  logic [adcac_pkg::CH_W-1:0]    start_ch;
  logic                          hw_prev;
  logic                          hw_edge;
  logic                          load;
  logic                          can_start;
  logic                          conv_done;
  logic                          src_ev;
  logic                          res_ev;

  assign loop_ch[0] = loop0_ch_i;
  assign loop_ch[1] = loop1_ch_i;
  assign pend_o     = pend;
  assign cal_run_o  = (state == adcac_pkg::ST_STARTUP_CAL_START);
  assign conv_done  = (state == adcac_pkg::ST_CONV) && core_done_i;
  assign start_ch   = hi_ch(pend);

  // ****************************************
  // Analog power control
  // ****************************************
  // Only the power state flops here, so configuration survives
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ana_pd_o <= adcac_pkg::PD_RST;
    end else begin
      ana_pd_o <= analog_powerdown_i;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Wakeup settling is left to software; no wait here
  // Powered-down idle must not clear a pending bit it cannot issue
  assign can_start = !ana_pd_o && (pend != '0) && !(wfr_en_i && result_valid_o);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= adcac_pkg::ST_OFF;
    end else begin
      unique case (state)
        adcac_pkg::ST_OFF: begin
          if (!ana_pd_o && cal_done_o) begin
            state <= adcac_pkg::ST_IDLE;
          end else if (!ana_pd_o && startup_cal_start_i) begin
            state <= adcac_pkg::ST_STARTUP_CAL_START;
          end
        end
        adcac_pkg::ST_STARTUP_CAL_START: begin
          if (ana_pd_o) begin
            state <= adcac_pkg::ST_OFF;
          end else if (cal_cnt == adcac_pkg::STARTUP_CAL_START_LAST) begin
            state <= adcac_pkg::ST_IDLE;
          end
        end
        adcac_pkg::ST_IDLE: begin
          if (ana_pd_o) begin
            state <= adcac_pkg::ST_OFF;
          end else if (can_start) begin
            state <= adcac_pkg::ST_CONV;
          end
        end
        adcac_pkg::ST_CONV: begin
          if (core_done_i) begin
            state <= adcac_pkg::ST_BGCAL;
          end
        end
        adcac_pkg::ST_BGCAL: begin
          if (core_done_i) begin
            state <= adcac_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= adcac_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // Startup calibration
  // ****************************************
  // Aborted by powerdown; must then be restarted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cal_cnt <= '0;
    end else if (state == adcac_pkg::ST_STARTUP_CAL_START) begin
      cal_cnt <= cal_cnt + 1'b1;
    end else begin
      cal_cnt <= '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cal_done_o <= 1'b0;
    end else if (state == adcac_pkg::ST_STARTUP_CAL_START && !ana_pd_o &&
                 cal_cnt == adcac_pkg::STARTUP_CAL_START_LAST) begin
      cal_done_o <= 1'b1;
    end
  end

  // ****************************************
  // Conversion issue
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_start_o <= 1'b0;
      conv_ch_o    <= '0;
      resid_o      <= '0;
      resid_en_o   <= 1'b0;
    end else begin
      conv_start_o <= (state == adcac_pkg::ST_IDLE) && !ana_pd_o &&
                      can_start;
      if (state == adcac_pkg::ST_IDLE && can_start) begin
        conv_ch_o  <= start_ch;
        resid_o    <= '0;
        resid_en_o <= 1'b0;
        // Loop 1 wins when both share one channel
        for (int i = 0; i < adcac_pkg::LOOP_N; i++) begin
          if (loop_hit(loop_en_i[i], loop_ch[i], start_ch)) begin
            resid_o    <= resid[i];
            resid_en_o <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Background calibration
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bg_start_o <= 1'b0;
      bg_gain_o  <= 1'b0;
    end else begin
      bg_start_o <= conv_done;
      if (state == adcac_pkg::ST_BGCAL && core_done_i) begin
        bg_gain_o <= !bg_gain_o;
      end
    end
  end

  // ****************************************
  // Sigma-delta residues
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < adcac_pkg::LOOP_N; g++) begin : g_loop
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          resid[g] <= '0;
        end else if (conv_done &&
                     loop_hit(loop_en_i[g], loop_ch[g], conv_ch_o)) begin
          resid[g] <= core_resid_i;
        end
      end
    end
  endgenerate

  // ****************************************
  // Request source
  // ****************************************
  assign hw_edge  = hw_trig_en_i && hw_trig_i[hw_trig_sel_i] && !hw_prev;
  assign src_ev   = conv_done && (pend == '0);
  assign load     = sw_trig_i || hw_edge || (src_ev && autoscan_i);
  assign load_pat = scan_en_i ? chan_sel_i :
                    adcac_pkg::NCH'(1) << single_ch_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hw_prev <= 1'b0;
    end else begin
      hw_prev <= hw_trig_i[hw_trig_sel_i];
    end
  end

  // Load overwrites and wins over the start clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= adcac_pkg::PEND_RST;
    end else if (load) begin
      pend <= load_pat;
    end else if (state == adcac_pkg::ST_IDLE && can_start) begin
      pend[start_ch] <= 1'b0;
    end
  end

  // ****************************************
  // Result and data reduction
  // ****************************************
  assign next_acc = (acc_cnt == '0 ? '0 : acc) +
                    adcac_pkg::ACC_W'(core_result_i);
  assign res_ev   = conv_done && (!dr_en_i || acc_cnt == dr_len_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc     <= '0;
      acc_cnt <= '0;
    end else if (conv_done && dr_en_i) begin
      acc     <= next_acc;
      acc_cnt <= (acc_cnt == dr_len_i) ? '0 : acc_cnt + 1'b1;
    end else if (!dr_en_i) begin
      acc_cnt <= '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_o    <= adcac_pkg::ACC_W'(adcac_pkg::RES_RST);
      result_ch_o <= '0;
    end else if (res_ev) begin
      result_o    <= dr_en_i ? next_acc :
                     adcac_pkg::ACC_W'(core_result_i);
      result_ch_o <= conv_ch_o;
    end
  end

  // New data beats a read in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_valid_o <= 1'b0;
    end else if (res_ev) begin
      result_valid_o <= 1'b1;
    end else if (result_read_i) begin
      result_valid_o <= 1'b0;
    end
  end

  adcac_ev_route u_route (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .src_ev_i   (src_ev),
    .res_ev_i   (res_ev),
    .src_node_i (src_node_i),
    .res_node_i (res_node_i),
    .sr_o       (sr_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  chk_pd_no_start: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_start_o |-> !$past(ana_pd_o))
    else $error("conversion issued while powered down");
  chk_pd_keeps_cfg: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $changed(ana_pd_o) && !$past(conv_done) |-> $stable(resid[0]))
    else $error("powerdown altered loop state");
  chk_cal_gate: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_start_o |-> cal_done_o)
    else $error("conversion before startup calibration");
  chk_cal_length: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(cal_done_o) |-> $past(cal_cnt) == adcac_pkg::STARTUP_CAL_START_LAST)
    else $error("startup calibration length wrong");
  chk_bg_after_conv: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_done |=> bg_start_o && state == adcac_pkg::ST_BGCAL)
    else $error("no calibration cycle after conversion");
  chk_wfr_block: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_start_o |-> !$past(wfr_en_i && result_valid_o))
    else $error("unread result would be overwritten");
  chk_src_event: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_done && pend == '0 |=> sr_o[$past(src_node_i)])
    else $error("sequence end raised no source event");
  chk_trig_pending: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    sw_trig_i && load_pat != '0 |=> pend != '0)
    else $error("software trigger lost");
  chk_resid_use: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    conv_start_o && loop_hit(loop_en_i[1], loop_ch[1], conv_ch_o) |->
    resid_en_o && resid_o == resid[1])
    else $error("residue not handed to next sample");
endmodule : adcac_ctrl
`default_nettype wire

// [bench/adcac_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Converter core stand-in
// ****************************************
module adcac_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        conv_start_i,
  input  wire logic        bg_start_i,
  input  wire logic [2:0]  conv_ch_i,
  input  wire logic [7:0]  delay_i,
  output logic             core_done_o,
  output logic [11:0]      core_result_o,
  output logic [7:0]       core_resid_o
);
  logic [7:0] cnt;
  logic       busy;
  logic [8:0] seq;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy          <= 1'b0;
      cnt           <= 8'h00;
      seq           <= 9'h000;
      core_done_o   <= 1'b0;
      core_result_o <= 12'hFFF;
      core_resid_o  <= 8'hFF;
    end else begin
      core_done_o   <= 1'b0;
      // Stale data flips every cycle so it is never mistaken for a result
      core_result_o <= ~core_result_o;
      core_resid_o  <= ~core_resid_o;
      if (conv_start_i || bg_start_i) begin
        busy <= 1'b1;
        cnt  <= delay_i;
      end else if (busy) begin
        if (cnt == 8'h00) begin
          busy          <= 1'b0;
          core_done_o   <= 1'b1;
          seq           <= seq + 9'h001;
          core_result_o <= {conv_ch_i, seq};
          core_resid_o  <= seq[7:0] ^ 8'h5A;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : adcac_core_model
`default_nettype wire

// [bench/adcac_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module adcac_ctrl_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk_i = 1'b0, rst_b_i, analog_powerdown_i, startup_cal_start_i, scan_en_i, autoscan_i, sw_trig_i;
  logic        hw_trig_en_i, wfr_en_i, result_read_i, dr_en_i, core_done_i, ana_pd_o, cal_run_o, cal_done_o;
  logic        conv_start_o, resid_en_o, bg_start_o, bg_gain_o, result_valid_o;
  logic [7:0]  chan_sel_i, core_resid_i, resid_o, pend_o, delay;
  logic [2:0]  single_ch_i, loop0_ch_i, loop1_ch_i, conv_ch_o, result_ch_o;
  logic [3:0]  hw_trig_i, sr_o;
  logic [1:0]  hw_trig_sel_i, loop_en_i, dr_len_i, src_node_i, res_node_i;
  logic [11:0] core_result_i;
  logic [13:0] result_o, acc_sum = 14'h0000;
  logic [7:0]  last_resid [8];
  logic [7:0]  seen = 8'h00;
  logic        gain = 1'b0;
  integer      seed = 32'h4ed1;
  int          n_errors = 0, samples_checked = 0, cycles = 0, acc_cnt = 0, n;

  always #12.5 clk_i = ~clk_i;

  adcac_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .analog_powerdown_i(analog_powerdown_i),
    .startup_cal_start_i(startup_cal_start_i), .chan_sel_i(chan_sel_i), .scan_en_i(scan_en_i),
    .single_ch_i(single_ch_i), .autoscan_i(autoscan_i), .sw_trig_i(sw_trig_i), .hw_trig_i(hw_trig_i),
    .hw_trig_sel_i(hw_trig_sel_i), .hw_trig_en_i(hw_trig_en_i), .loop_en_i(loop_en_i),
    .loop0_ch_i(loop0_ch_i), .loop1_ch_i(loop1_ch_i), .wfr_en_i(wfr_en_i), .result_read_i(result_read_i),
    .dr_en_i(dr_en_i), .dr_len_i(dr_len_i), .src_node_i(src_node_i), .res_node_i(res_node_i),
    .core_done_i(core_done_i), .core_result_i(core_result_i), .core_resid_i(core_resid_i),
    .ana_pd_o(ana_pd_o), .cal_run_o(cal_run_o), .cal_done_o(cal_done_o), .conv_start_o(conv_start_o),
    .conv_ch_o(conv_ch_o), .resid_o(resid_o), .resid_en_o(resid_en_o), .bg_start_o(bg_start_o),
    .bg_gain_o(bg_gain_o), .result_o(result_o), .result_ch_o(result_ch_o),
    .result_valid_o(result_valid_o), .pend_o(pend_o), .sr_o(sr_o));

  adcac_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_start_i(conv_start_o),
    .bg_start_i(bg_start_o), .conv_ch_i(conv_ch_o), .delay_i(delay), .core_done_o(core_done_i),
    .core_result_o(core_result_i), .core_resid_o(core_resid_i));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [13:0] e, input logic [13:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  // Inputs move 1 ns after the edge so the sampling edge never races them
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick

  function automatic logic [7:0] load_pat();
    return scan_en_i ? chan_sel_i : 8'h01 << single_ch_i;
  endfunction : load_pat

  function automatic logic loop_on(input logic [2:0] c);
    return (loop_en_i[0] && loop0_ch_i == c) || (loop_en_i[1] && loop1_ch_i == c);
  endfunction : loop_on

  task automatic pulse_sw();
    sw_trig_i = 1'b1;
    tick(1);
    sw_trig_i = 1'b0;
  endtask : pulse_sw

  // Follows one request pattern through conversion and background cycles
  task automatic run_seq(input logic [7:0] p, input logic wfr);
    logic [11:0] r;
    logic        ev;
    logic        last;
    for (int c = 7; c >= 0; c--) begin
      if (p[c]) begin
        for (int i = 0; i < 400 && conv_start_o !== 1'b1; i++) tick(1);
        chk_bit("conv_start", 1'b1, conv_start_o);
        chk_vec("conv_ch", 14'(c), 14'(conv_ch_o));
        chk_bit("resid_en", loop_on(3'(c)), resid_en_o);
        if (loop_on(3'(c)) && seen[c]) chk_vec("resid", 14'(last_resid[c]), 14'(resid_o));
        for (int i = 0; i < 400 && core_done_i !== 1'b1; i++) tick(1);
        r = core_result_i;
        if (loop_on(3'(c))) begin
          last_resid[c] = core_resid_i;
          seen[c] = 1'b1;
        end
        last = (p & ((8'h01 << c) - 8'h01)) == 8'h00;
        acc_sum = acc_sum + 14'(r);
        acc_cnt++;
        ev = !dr_en_i || acc_cnt == int'(dr_len_i) + 1;
        tick(1);
        chk_bit("bg_start", 1'b1, bg_start_o);
        chk_bit("bg_gain", gain, bg_gain_o);
        gain = ~gain;
        chk_vec("sr", 14'((ev ? 4'h1 << res_node_i : 4'h0) | (last ? 4'h1 << src_node_i : 4'h0)), 14'(sr_o));
        if (ev) begin
          chk_vec("result", acc_sum, result_o);
          chk_vec("result_ch", 14'(c), 14'(result_ch_o));
          chk_bit("valid", 1'b1, result_valid_o);
          acc_sum = 14'h0000;
          acc_cnt = 0;
        end
        if (wfr && !last) begin
          repeat (20) begin
            tick(1);
            chk_bit("wfr_hold", 1'b0, conv_start_o);
          end
        end
        result_read_i = 1'b1;
        tick(1);
        result_read_i = 1'b0;
      end
    end
  endtask : run_seq

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b_i, startup_cal_start_i, scan_en_i, autoscan_i, sw_trig_i, hw_trig_en_i} = 6'h00;
    {wfr_en_i, result_read_i, hw_trig_i, hw_trig_sel_i, chan_sel_i, single_ch_i} = 19'h00000;
    analog_powerdown_i = 1'b1;
    dr_en_i = 1'b1;
    dr_len_i = 2'h1;
    loop_en_i = 2'h3;
    loop0_ch_i = 3'h7;
    loop1_ch_i = 3'h3;
    src_node_i = 2'h1;
    res_node_i = 2'h2;
    delay = 8'h02;
    repeat (6) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk_bit("pd_reset", 1'b1, ana_pd_o);
    chk_bit("done_reset", 1'b0, cal_done_o);
    startup_cal_start_i = 1'b1;
    tick(5);
    chk_bit("cal_refused", 1'b0, cal_run_o);
    startup_cal_start_i = 1'b0;
    analog_powerdown_i = 1'b0;
    tick(1);
    chk_bit("pd_off", 1'b0, ana_pd_o);
    tick(40);
    scan_en_i = 1'b1;
    chan_sel_i = 8'h88;
    pulse_sw();
    repeat (10) begin
      tick(1);
      chk_bit("early_start", 1'b0, conv_start_o);
    end
    chk_vec("pend_held", 14'h0088, 14'(pend_o));
    startup_cal_start_i = 1'b1;
    tick(1);
    startup_cal_start_i = 1'b0;
    chk_bit("cal_run", 1'b1, cal_run_o);
    n = 0;
    while (cal_done_o !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk_vec("cal_len", 14'h0960, 14'(n));
    chk_bit("cal_run_end", 1'b0, cal_run_o);
    run_seq(8'h88, 1'b0);
    dr_en_i = 1'b0;
    for (int t = 0; t < 12; t++) begin
      scan_en_i = 1'($random(seed));
      chan_sel_i = 8'($random(seed));
      if (chan_sel_i == 8'h00) chan_sel_i = 8'h81;
      single_ch_i = 3'($random(seed));
      src_node_i = 2'($random(seed));
      res_node_i = 2'($random(seed));
      hw_trig_sel_i = 2'($random(seed));
      delay = (t == 5) ? 8'h19 : 8'($random(seed)) & 8'h07;
      if (t[0]) begin
        hw_trig_en_i = 1'b1;
        hw_trig_i = ~(4'h1 << hw_trig_sel_i);
        tick(3);
        chk_vec("pend_other_line", 14'h0000, 14'(pend_o));
        hw_trig_i = 4'hF;
        tick(1);
        hw_trig_i = 4'h0;
      end else begin
        pulse_sw();
      end
      run_seq(load_pat(), 1'b0);
      tick(40);
    end
    scan_en_i = 1'b0;
    single_ch_i = 3'h6;
    // Load lands while still idle, so powered-down idle must keep it
    analog_powerdown_i = 1'b1;
    pulse_sw();
    chk_bit("pd_on", 1'b1, ana_pd_o);
    repeat (30) begin
      tick(1);
      chk_bit("pd_start", 1'b0, conv_start_o);
    end
    chk_vec("pend_pd", 14'h0040, 14'(pend_o));
    chk_bit("done_pd", 1'b1, cal_done_o);
    analog_powerdown_i = 1'b0;
    run_seq(8'h40, 1'b0);
    tick(40);
    wfr_en_i = 1'b1;
    scan_en_i = 1'b1;
    chan_sel_i = 8'h30;
    pulse_sw();
    run_seq(8'h30, 1'b1);
    wfr_en_i = 1'b0;
    tick(40);
    autoscan_i = 1'b1;
    scan_en_i = 1'b0;
    single_ch_i = 3'h1;
    pulse_sw();
    run_seq(8'h02, 1'b0);
    autoscan_i = 1'b0;
    run_seq(8'h02, 1'b0);
    results();
  end
endmodule : adcac_ctrl_tb
`default_nettype wire
